// >>> hdl/swf_pkg.sv
// Shared constants and types for the serial wire debug target framing block.
package swf_pkg;
  // Wire bit counts.
  localparam logic [5:0] REQ_LAST  = 6'h07;  // Index of the park bit in a request.
  localparam logic [5:0] ACK_LAST  = 6'h03;  // Acknowledge bits driven before the data phase.
  localparam logic [5:0] DATA_LAST = 6'h21;  // 32 data bits plus one parity bit.
  localparam int         DATA_W    = 32;
  localparam int         TX_W      = 36;     // Acknowledge, data and parity in one shift.
  localparam int         TURN_W    = 2;      // Width of the turnaround length field.
  // Request bit positions, in wire order.
  localparam int REQ_START  = 0;
  localparam int REQ_APNDP  = 1;
  localparam int REQ_RNW    = 2;
  localparam int REQ_A2     = 3;
  localparam int REQ_A3     = 4;
  localparam int REQ_PARITY = 5;
  localparam int REQ_STOP   = 6;
  localparam int REQ_PARK   = 7;
  // Acknowledge codes.
  localparam logic [2:0] ACK_OK    = 3'h1;
  localparam logic [2:0] ACK_WAIT  = 3'h2;
  localparam logic [2:0] ACK_FAULT = 3'h4;
  // Reset values.
  localparam logic [2:0]  ACK_RST   = ACK_WAIT;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;
  // Link-side sequencer states.
  typedef enum logic [2:0] {
    LK_IDLE, LK_REQ, LK_TURN1, LK_ACK, LK_RDATA, LK_TURN2, LK_WTURN, LK_WDATA
  } swf_link_t;
  // Port selection states after power-up.
  typedef enum logic [1:0] {
    SEL_BOOT, SEL_JTAG, SEL_DORMANT, SEL_WIRE
  } swf_sel_t;
endpackage : swf_pkg

// >>> hdl/swf_target.sv
// Target end of the two-wire serial debug link: framing, turnaround and port selection.
`timescale 1ns/1ps
`default_nettype none
module swf_target (
  // System clock and reset.
  input  wire  logic                        mclk_in,
  input  wire  logic                        reset_n_in,
  // Link clock and data pin.
  input  wire  logic                        swclk_in,
  input  wire  logic                        swdio_in,
  output logic                              swdio_out,
  output logic                              swdio_oe_n_out,
  // Port configuration.
  input  wire  logic                        combined_port_in,
  input  wire  logic                        wire_select_in,
  input  wire  logic                        wire_deselect_in,
  input  wire  logic                        overrun_detect_enable_in,
  input  wire  logic [swf_pkg::TURN_W-1:0]  turnaround_length_field_in,
  // Prepared response for the next operation.
  input  wire  logic                        rsp_load_in,
  input  wire  logic [2:0]                  rsp_ack_in,
  input  wire  logic [swf_pkg::DATA_W-1:0]  rsp_rdata_in,
  // Completed operation report.
  output logic                              op_done_out,
  output logic                              op_rnw_out,
  output logic                              op_apndp_out,
  output logic [1:0]                        op_addr_out,
  output logic [2:0]                        op_ack_out,
  output logic [swf_pkg::DATA_W-1:0]        op_wdata_out,
  output logic                              op_wpar_err_out,
  output logic                              op_proto_err_out,
  // Selection status.
  output logic                              wire_active_out,
  output logic                              jtag_selected_out,
  output logic                              power_down_ok_out
);

  ////////////////////////////////////////////////////////////////////////////
  // System clock domain: strap capture and port selection.

  logic                       strap_s1_r;
  logic                       strap_s2_r;
  swf_pkg::swf_sel_t          sel_r;
  logic                       rsp_tgl_r;
  logic [2:0]                 hold_ack_r;
  logic [swf_pkg::DATA_W-1:0] hold_rdata_r;
  logic                       ev_s1_r;
  logic                       ev_s2_r;
  logic                       ev_s3_r;

  // The strap is a pin, so it passes two flops before the selector reads it.
  always_ff @(posedge mclk_in)
  begin
    strap_s1_r <= combined_port_in;
    strap_s2_r <= strap_s1_r;
  end

  // Start state is taken one edge after reset release, from the synced strap.
  always_ff @(posedge mclk_in)
  begin
    if (!reset_n_in)
      sel_r <= swf_pkg::SEL_BOOT;
    else
      unique case (sel_r)
        swf_pkg::SEL_BOOT:
          sel_r <= strap_s2_r ? swf_pkg::SEL_JTAG : swf_pkg::SEL_DORMANT;
        swf_pkg::SEL_JTAG, swf_pkg::SEL_DORMANT:
          if (wire_select_in)
            sel_r <= swf_pkg::SEL_WIRE;
        swf_pkg::SEL_WIRE:
          if (wire_deselect_in)
            sel_r <= strap_s2_r ? swf_pkg::SEL_JTAG : swf_pkg::SEL_DORMANT;
      endcase
  end

  // Status flops; a dormant target may drop its power.
  always_ff @(posedge mclk_in)
  begin
    if (!reset_n_in)
    begin
      wire_active_out   <= 1'b0;
      jtag_selected_out <= 1'b0;
      power_down_ok_out <= 1'b0;
    end
    else
    begin
      wire_active_out   <= (sel_r == swf_pkg::SEL_WIRE);
      jtag_selected_out <= (sel_r == swf_pkg::SEL_JTAG);
      power_down_ok_out <= (sel_r == swf_pkg::SEL_DORMANT);
    end
  end

  // Response holding register; the toggle tells the link a new word is stable.
  always_ff @(posedge mclk_in)
  begin
    if (!reset_n_in)
    begin
      rsp_tgl_r    <= 1'b0;
      hold_ack_r   <= swf_pkg::ACK_RST;
      hold_rdata_r <= swf_pkg::RDATA_RST;
    end
    else if (rsp_load_in)
    begin
      rsp_tgl_r    <= ~rsp_tgl_r;
      hold_ack_r   <= rsp_ack_in;
      hold_rdata_r <= rsp_rdata_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link clock domain: synchronisers.

  logic                       lrst_s1_r;
  logic                       lrst_n_r;
  logic                       act_s1_r;
  logic                       act_s2_r;
  logic                       orun_s1_r;
  logic                       orun_s2_r;
  logic [swf_pkg::TURN_W-1:0] turn_s1_r;
  logic [swf_pkg::TURN_W-1:0] turn_s2_r;
  logic                       rt_s1_r;
  logic                       rt_s2_r;
  logic                       rt_s3_r;
  logic [2:0]                 l_ack_r;
  logic [swf_pkg::DATA_W-1:0] l_rdata_r;

  // Reset and quasi-static levels cross on two flops each.
  always_ff @(posedge swclk_in)
  begin
    lrst_s1_r <= reset_n_in;
    lrst_n_r  <= lrst_s1_r;
    act_s1_r  <= wire_active_out;
    act_s2_r  <= act_s1_r;
    orun_s1_r <= overrun_detect_enable_in;
    orun_s2_r <= orun_s1_r;
    turn_s1_r <= turnaround_length_field_in;
    turn_s2_r <= turn_s1_r;
    rt_s1_r   <= rsp_tgl_r;
    rt_s2_r   <= rt_s1_r;
    rt_s3_r   <= rt_s2_r;
  end

  // The holding word is stable once its toggle is seen, so it is copied here.
  always_ff @(posedge swclk_in)
  begin
    if (!lrst_n_r)
    begin
      l_ack_r   <= swf_pkg::ACK_RST;
      l_rdata_r <= swf_pkg::RDATA_RST;
    end
    else if (rt_s2_r != rt_s3_r)
    begin
      l_ack_r   <= hold_ack_r;
      l_rdata_r <= hold_rdata_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link clock domain: sequencer.

  swf_pkg::swf_link_t         st_r;
  logic [5:0]                 cnt_r;
  logic [2:0]                 tcnt_r;
  logic [swf_pkg::REQ_LAST:0] req_r;
  logic [swf_pkg::DATA_W:0]   wsh_r;
  logic [swf_pkg::TX_W-1:0]   tx_r;
  logic                       ev_tgl_r;
  logic [swf_pkg::REQ_LAST:0] req_full;
  logic                       req_good;
  logic                       req_end;
  logic                       turn_done;
  logic                       ack_end;
  logic                       data_ph;
  logic                       rd_end;
  logic                       wr_end;
  logic                       keep_drive;

  // The park bit is still on the pin when the request is judged.
  assign req_full  = {swdio_in, req_r[swf_pkg::REQ_STOP:0]};
  assign req_good  = req_full[swf_pkg::REQ_START] & ~req_full[swf_pkg::REQ_STOP]
                   & req_full[swf_pkg::REQ_PARK]
                   & ~(^req_full[swf_pkg::REQ_PARITY:swf_pkg::REQ_APNDP]);
  assign req_end   = (st_r == swf_pkg::LK_REQ) && (cnt_r == swf_pkg::REQ_LAST);
  assign turn_done = (tcnt_r == {1'b0, turn_s2_r});
  assign ack_end   = (st_r == swf_pkg::LK_ACK) && (cnt_r == swf_pkg::ACK_LAST);
  assign data_ph   = (l_ack_r == swf_pkg::ACK_OK) || orun_s2_r;
  assign rd_end    = (st_r == swf_pkg::LK_RDATA) && (cnt_r == swf_pkg::DATA_LAST);
  assign wr_end    = (st_r == swf_pkg::LK_WDATA) && (cnt_r == swf_pkg::DATA_LAST);
  assign keep_drive = ((st_r == swf_pkg::LK_ACK) && !ack_end)
                    || (ack_end && data_ph && req_r[swf_pkg::REQ_RNW])
                    || ((st_r == swf_pkg::LK_RDATA) && !rd_end);

  // Phase sequencing; an unselected target never leaves idle.
  always_ff @(posedge swclk_in)
  begin
    if (!lrst_n_r)
    begin
      st_r   <= swf_pkg::LK_IDLE;
      cnt_r  <= 6'h00;
      tcnt_r <= 3'h0;
    end
    else
    begin
      cnt_r  <= cnt_r + 6'h01;
      tcnt_r <= tcnt_r + 3'h1;
      unique case (st_r)
        swf_pkg::LK_IDLE:
        begin
          cnt_r <= 6'h01;
          if (act_s2_r && swdio_in)                      // Low bits are idle.
            st_r <= swf_pkg::LK_REQ;
        end
        swf_pkg::LK_REQ:
          if (req_end)
          begin
            tcnt_r <= 3'h0;
            st_r   <= req_good ? swf_pkg::LK_TURN1 : swf_pkg::LK_IDLE;
          end
        swf_pkg::LK_TURN1:
          if (turn_done)
          begin
            cnt_r <= 6'h01;
            st_r  <= swf_pkg::LK_ACK;
          end
        swf_pkg::LK_ACK:
          if (ack_end)
          begin
            cnt_r  <= 6'h01;
            tcnt_r <= 3'h0;
            if (!data_ph)
              st_r <= swf_pkg::LK_TURN2;
            else if (req_r[swf_pkg::REQ_RNW])
              st_r <= swf_pkg::LK_RDATA;
            else
              st_r <= swf_pkg::LK_WTURN;
          end
        swf_pkg::LK_RDATA:
          if (rd_end)
          begin
            tcnt_r <= 3'h0;
            st_r   <= swf_pkg::LK_TURN2;
          end
        swf_pkg::LK_TURN2:
          if (turn_done)
            st_r <= swf_pkg::LK_IDLE;
        swf_pkg::LK_WTURN:
          if (turn_done)
          begin
            cnt_r <= 6'h01;
            st_r  <= swf_pkg::LK_WDATA;
          end
        swf_pkg::LK_WDATA:
          if (wr_end)
            st_r <= swf_pkg::LK_IDLE;                   // Host keeps the wire.
      endcase
    end
  end

  // Pin drive. The enable is only low in acknowledge and read data, so a
  // target deselected while idle never fights another device, though one deselected
  // mid-operation still drives the rest of that operation; the level is driven
  // actively both ways rather than by a pull.
  always_ff @(posedge swclk_in)
  begin
    if (!lrst_n_r)
    begin
      swdio_out      <= 1'b0;
      swdio_oe_n_out <= 1'b1;
      tx_r           <= '0;
    end
    else if ((st_r == swf_pkg::LK_TURN1) && turn_done)
    begin
      swdio_out      <= l_ack_r[0];
      swdio_oe_n_out <= 1'b0;
      tx_r           <= {1'b0, ^l_rdata_r, l_rdata_r, l_ack_r[2:1]};
    end
    else if (keep_drive)
    begin
      swdio_out <= tx_r[0];
      tx_r      <= {1'b0, tx_r[swf_pkg::TX_W-1:1]};
    end
    else
    begin
      swdio_out      <= 1'b0;
      swdio_oe_n_out <= 1'b1;                            // Turnaround release.
    end
  end

  // Request and write data capture; every finished operation flips the toggle.
  always_ff @(posedge swclk_in)
  begin
    if (!lrst_n_r)
    begin
      req_r    <= '0;
      wsh_r    <= '0;
      ev_tgl_r <= 1'b0;
    end
    else
    begin
      // Only a start bit reloads it, so idle cycles leave the last request for the report.
      if ((st_r == swf_pkg::LK_IDLE) && act_s2_r && swdio_in)
        req_r <= {{swf_pkg::REQ_LAST{1'b0}}, swdio_in};
      else if (st_r == swf_pkg::LK_REQ)
        req_r[cnt_r[2:0]] <= swdio_in;
      if (st_r == swf_pkg::LK_WDATA)
        wsh_r <= {swdio_in, wsh_r[swf_pkg::DATA_W:1]};
      if ((req_end && !req_good) || (ack_end && !data_ph) || rd_end || wr_end)
        ev_tgl_r <= ~ev_tgl_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // System clock domain: operation report.

  logic       req_bad;
  logic       wpar_err;

  // The link may stop its clock after an operation, so the report is carried
  // by a toggle and held registers, never by a link-side pulse.
  always_ff @(posedge mclk_in)
  begin
    ev_s1_r <= ev_tgl_r;
    ev_s2_r <= ev_s1_r;
    ev_s3_r <= ev_s2_r;
  end

  // A rejected request leaves the state machine in idle with no data phase.
  assign req_bad    = ~req_r[swf_pkg::REQ_PARK] | req_r[swf_pkg::REQ_STOP]
                    | (^req_r[swf_pkg::REQ_PARITY:swf_pkg::REQ_APNDP]);
  assign wpar_err   = (^wsh_r[swf_pkg::DATA_W-1:0]) ^ wsh_r[swf_pkg::DATA_W];

  // Report flops, loaded when the event toggle settles.
  always_ff @(posedge mclk_in)
  begin
    if (!reset_n_in)
    begin
      op_done_out      <= 1'b0;
      op_rnw_out       <= 1'b0;
      op_apndp_out     <= 1'b0;
      op_addr_out      <= 2'h0;
      op_ack_out       <= swf_pkg::ACK_RST;
      op_wdata_out     <= swf_pkg::RDATA_RST;
      op_wpar_err_out  <= 1'b0;
      op_proto_err_out <= 1'b0;
    end
    else
    begin
      op_done_out <= (ev_s2_r != ev_s3_r);
      if (ev_s2_r != ev_s3_r)
      begin
        op_rnw_out       <= req_r[swf_pkg::REQ_RNW];
        op_apndp_out     <= req_r[swf_pkg::REQ_APNDP];
        op_addr_out      <= req_r[swf_pkg::REQ_A3:swf_pkg::REQ_A2];
        op_ack_out       <= l_ack_r;
        op_wdata_out     <= wsh_r[swf_pkg::DATA_W-1:0];
        op_wpar_err_out  <= ~req_r[swf_pkg::REQ_RNW] & ~req_bad & wpar_err;
        op_proto_err_out <= req_bad;
      end
    end
  end

endmodule : swf_target
`default_nettype wire

// >>> tb/swf_host_model.sv
// Behavioural debug host that clocks and frames operations on the link.
`timescale 1ns/1ps
`default_nettype none
module swf_host_model (
  // Link clock and resolved line.
  output logic      swclk_out,
  output logic      swdio_out,
  // Target pin drive.
  input  wire logic t_bit_in,
  input  wire logic t_oe_n_in
);
  logic h_oe = 1'b0;
  logic h_bit = 1'b0;
  logic clash = 1'b0;
  int   tdrv;
  ////////////////////////////////////////
  // A pull-up holds the line high while nobody drives it.
  assign swdio_out = !t_oe_n_in ? t_bit_in : (h_oe ? h_bit : 1'b1);
  initial
    swclk_out = 1'b0;
  // One link cycle; the clock stands low between calls. The line is read just
  // before the rising edge, so a target bit launched on the last edge has settled.
  task automatic tick(input logic drv, input logic b, output logic s);
    h_oe = drv;
    h_bit = b;
    #15 s = swdio_out;
    swclk_out = 1'b1;
    #15 swclk_out = 1'b0;
    tdrv += int'(!t_oe_n_in);
    if (!t_oe_n_in && h_oe)
      clash = 1'b1;
  endtask : tick
  // Low idle cycles, which also let the transfer finish inside the target.
  task automatic idle(input int n);
    logic s;
    for (int i = 0; i < n; i++)
      tick(1'b1, 1'b0, s);
  endtask : idle
  // One operation; bad flips the request parity, data asks for a data phase.
  task automatic op(input logic rnw, input logic [1:0] a, input logic [31:0] wd,
                    input logic bad, input logic data, input int t,
                    output logic [2:0] ack, output logic [32:0] rd);
    logic [7:0] req;
    logic       s;
    req = {1'b1, 1'b0, ^{rnw, a} ^ bad, a[1], a[0], rnw, 1'b0, 1'b1};
    rd = 33'h0;
    tdrv = 0;
    #7;
    for (int i = 0; i < 8; i++)
      tick(1'b1, req[i], s);
    for (int i = 0; i < t; i++)
      tick(1'b0, 1'b0, s);
    for (int i = 0; i < 3; i++)
      tick(1'b0, 1'b0, ack[i]);
    for (int i = 0; i < 33 && data && rnw; i++)
      tick(1'b0, 1'b0, rd[i]);
    for (int i = 0; i < t; i++)
      tick(1'b0, 1'b0, s);
    for (int i = 0; i < 33 && data && !rnw; i++)
      tick(1'b1, i < 32 ? wd[i] : ^wd, s);
    idle(8);
  endtask : op
endmodule : swf_host_model
`default_nettype wire

// >>> tb/swf_target_properties.sv
// Port-level checks of the serial debug target framing.
`timescale 1ns/1ps
`default_nettype none
module swf_target_props (
  // Clocks and reset.
  input wire logic                       mclk_in,
  input wire logic                       reset_n_in,
  input wire logic                       swclk_in,
  // Link pins and strap.
  input wire logic                       swdio_in,
  input wire logic                       swdio_out,
  input wire logic                       swdio_oe_n_out,
  input wire logic                       combined_port_in,
  input wire logic [swf_pkg::TURN_W-1:0] turnaround_length_field_in,
  // Report and status.
  input wire logic                       op_done_out,
  input wire logic                       wire_active_out,
  input wire logic                       jtag_selected_out,
  input wire logic                       power_down_ok_out
);
  ////////////////////////////////////////
  // Length of the running drive burst; only 3 or 36 link cycles are legal.
  logic [5:0] low_cnt_r;
  always_ff @(posedge swclk_in)
  begin
    if (!reset_n_in || swdio_oe_n_out)
      low_cnt_r <= 6'h00;
    else
      low_cnt_r <= low_cnt_r + 6'h01;
  end
  burst_length_a : assert property (@(posedge swclk_in) disable iff (!reset_n_in)
    $rose(swdio_oe_n_out) |-> low_cnt_r == 6'h03 || low_cnt_r == 6'h24)
    else $error("drive burst length wrong");
  ack_code_a : assert property (@(posedge swclk_in) disable iff (!reset_n_in)
    $fell(swdio_oe_n_out) |-> (swdio_out ##1 !swdio_out ##1 !swdio_out) or
    (!swdio_out ##1 swdio_out ##1 !swdio_out) or (!swdio_out ##1 !swdio_out ##1 swdio_out))
    else $error("ack not one of three codes");
  ack_timing_a : assert property (@(posedge swclk_in) disable iff (!reset_n_in)
    $fell(swdio_oe_n_out) && turnaround_length_field_in == 2'h0 |->
    $past(swdio_in, 9) && !$past(swdio_in, 3) && $past(swdio_in, 2))
    else $error("ack not one turnaround after request");
  release_hold_a : assert property (@(posedge swclk_in) disable iff (!reset_n_in)
    $rose(swdio_oe_n_out) |-> swdio_oe_n_out [*8])
    else $error("target drove again too soon");
  done_pulse_a : assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    op_done_out |=> !op_done_out)
    else $error("op report longer than one cycle");
  boot_jtag_a : assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    $rose(reset_n_in) && combined_port_in |-> ##2 jtag_selected_out && !wire_active_out)
    else $error("combined port not in jtag after reset");
  boot_dormant_a : assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    $rose(reset_n_in) && !combined_port_in |-> ##2 power_down_ok_out && !jtag_selected_out)
    else $error("wire-only port not dormant after reset");
  quiet_dormant_a : assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    power_down_ok_out |-> swdio_oe_n_out && !wire_active_out)
    else $error("dormant target drives the line");
endmodule : swf_target_props
bind swf_target swf_target_props chk_u (.mclk_in, .reset_n_in, .swclk_in, .swdio_in,
  .swdio_out, .swdio_oe_n_out, .combined_port_in, .turnaround_length_field_in,
  .op_done_out, .wire_active_out, .jtag_selected_out, .power_down_ok_out);
`default_nettype wire

// >>> tb/swf_target_tb.sv
// Self-checking bench for the serial debug target framing block.
`timescale 1ns/1ps
`default_nettype none
module swf_target_tb;
  logic        mclk_in, reset_n_in, combined_port_in, wire_select_in, wire_deselect_in;
  logic        overrun_detect_enable_in, rsp_load_in, swclk_in, swdio_in, swdio_out;
  logic        swdio_oe_n_out, op_done_out, op_rnw_out, op_apndp_out, op_wpar_err_out;
  logic        op_proto_err_out, wire_active_out, jtag_selected_out, power_down_ok_out;
  logic [1:0]  turnaround_length_field_in, op_addr_out;
  logic [2:0]  rsp_ack_in, op_ack_out, got_ack;
  logic [31:0] rsp_rdata_in, op_wdata_out;
  logic [32:0] got_rd;
  int          failures = 0;
  int          total_checks = 0;
  ////////////////////////////////////////
  swf_target dut_u (.mclk_in, .reset_n_in, .swclk_in, .swdio_in, .swdio_out,
    .swdio_oe_n_out, .combined_port_in, .wire_select_in, .wire_deselect_in,
    .overrun_detect_enable_in, .turnaround_length_field_in, .rsp_load_in, .rsp_ack_in,
    .rsp_rdata_in, .op_done_out, .op_rnw_out, .op_apndp_out, .op_addr_out, .op_ack_out,
    .op_wdata_out, .op_wpar_err_out, .op_proto_err_out, .wire_active_out,
    .jtag_selected_out, .power_down_ok_out);
  swf_host_model host_u (.swclk_out(swclk_in), .swdio_out(swdio_in), .t_bit_in(swdio_out),
    .t_oe_n_in(swdio_oe_n_out));
  // System clock at 10 MHz.
  initial
  begin
    mclk_in = 1'b0;
    forever #50 mclk_in = ~mclk_in;
  end
  // Hang guard, far beyond the few hundred cycles the run needs.
  initial
  begin
    #600000;
    failures++;
    test_done();
  end
  task automatic chk(input logic ok, input string m);
    total_checks++;
    if (ok !== 1'b1)
    begin
      failures++;
      $display("BAD %0t %s", $time, m);
    end
  endtask : chk
  task automatic test_done;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : test_done
  // Reset with the link clocked too, since the link reset is resynchronised.
  task automatic rst(input logic comb);
    @(posedge mclk_in);
    combined_port_in <= comb;
    reset_n_in <= 1'b0;
    host_u.idle(4);
    repeat (3) @(posedge mclk_in);
    reset_n_in <= 1'b1;
    repeat (4) @(negedge mclk_in);
  endtask : rst
  task automatic pulse_sel(input logic desel);
    @(posedge mclk_in);
    wire_select_in <= !desel;
    wire_deselect_in <= desel;
    @(posedge mclk_in);
    wire_select_in <= 1'b0;
    wire_deselect_in <= 1'b0;
    repeat (8) @(negedge mclk_in);
    host_u.idle(4);
  endtask : pulse_sel
  task automatic load(input logic [2:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    rsp_load_in <= 1'b1;
    rsp_ack_in <= a;
    rsp_rdata_in <= d;
    @(posedge mclk_in);
    rsp_load_in <= 1'b0;
    repeat (6) @(posedge mclk_in);
  endtask : load
  // Runs one operation and waits, bounded, for its report.
  task automatic run(input logic rnw, input logic [1:0] a, input logic [31:0] wd,
                     input logic bad, input logic data);
    int n;
    n = 0;
    fork
      host_u.op(rnw, a, wd, bad, data, int'(turnaround_length_field_in) + 1, got_ack, got_rd);
      while (op_done_out !== 1'b1 && n < 300)
      begin
        @(negedge mclk_in);
        n++;
      end
    join
    chk(n < 300, "no operation report");
  endtask : run
  // Combined port boots in jtag, then serves a read after wire selection.
  task automatic t_jtag_read;
    rst(1'b1);
    chk(jtag_selected_out === 1'b1 && op_ack_out === swf_pkg::ACK_RST, "boot");
    pulse_sel(1'b0);
    chk(wire_active_out === 1'b1 && jtag_selected_out === 1'b0, "select");
    load(swf_pkg::ACK_OK, 32'hc350_00a7);
    run(1'b1, 2'h2, 32'h0, 1'b0, 1'b1);
    chk(got_ack === swf_pkg::ACK_OK && got_rd[31:0] === 32'hc350_00a7, "read");
    chk(got_rd[32] === ^32'hc350_00a7, "read parity");
    chk(host_u.tdrv == 36, "read drive span");
    chk(op_rnw_out === 1'b1 && op_addr_out === 2'h2, "read report");
    chk(op_apndp_out === 1'b0, "read port select");
  endtask : t_jtag_read
  // Write with a two-cycle turnaround.
  task automatic t_write;
    @(posedge mclk_in);
    turnaround_length_field_in <= 2'h1;
    @(posedge mclk_in);
    run(1'b0, 2'h1, 32'h8e01_f00d, 1'b0, 1'b1);
    chk(host_u.tdrv == 3 && op_wdata_out === 32'h8e01_f00d, "write");
    chk(op_wpar_err_out === 1'b0 && op_rnw_out === 1'b0, "write report");
    @(posedge mclk_in);
    turnaround_length_field_in <= 2'h0;
  endtask : t_write
  // Wait and fault answers, with and without overrun detection.
  task automatic t_not_ok;
    logic [2:0] a;
    for (int i = 0; i < 8; i++)
    begin
      a = i[0] ? swf_pkg::ACK_FAULT : swf_pkg::ACK_WAIT;
      @(posedge mclk_in);
      overrun_detect_enable_in <= i[1];
      load(a, 32'h0f0f_3c3c);
      run(i[2], 2'h3, 32'h1234_5678, 1'b0, i[1]);
      chk(got_ack === a && op_ack_out === a, "refused ack");
      chk(host_u.tdrv == ((i[1] && i[2]) ? 36 : 3), "data phase presence");
    end
    @(posedge mclk_in);
    overrun_detect_enable_in <= 1'b0;
  endtask : t_not_ok
  // Request with bad parity: no answer at all.
  task automatic t_bad_req;
    load(swf_pkg::ACK_OK, 32'h0);
    run(1'b1, 2'h0, 32'h0, 1'b1, 1'b0);
    chk(host_u.tdrv == 0 && op_proto_err_out === 1'b1, "bad request");
  endtask : t_bad_req
  // Wire-only port boots dormant, works as before once selected, then sleeps.
  task automatic t_dormant;
    rst(1'b0);
    chk(power_down_ok_out === 1'b1 && jtag_selected_out === 1'b0, "boot");
    pulse_sel(1'b0);
    chk(wire_active_out === 1'b1 && power_down_ok_out === 1'b0, "select");
    load(swf_pkg::ACK_OK, 32'h0000_0001);
    run(1'b1, 2'h0, 32'h0, 1'b0, 1'b1);
    chk(host_u.tdrv == 36 && got_rd === {1'b1, 32'h1}, "read");
    pulse_sel(1'b1);
    chk(power_down_ok_out === 1'b1 && wire_active_out === 1'b0, "sleep");
  endtask : t_dormant
  // Main sequence.
  initial
  begin
    reset_n_in <= 1'b0;
    combined_port_in <= 1'b1;
    wire_select_in <= 1'b0;
    wire_deselect_in <= 1'b0;
    overrun_detect_enable_in <= 1'b0;
    turnaround_length_field_in <= 2'h0;
    rsp_load_in <= 1'b0;
    rsp_ack_in <= 3'h0;
    rsp_rdata_in <= 32'h0;
    t_jtag_read();
    t_write();
    t_not_ok();
    t_bad_req();
    t_dormant();
    chk(host_u.clash === 1'b0, "line contention");
    test_done();
  end
endmodule : swf_target_tb
`default_nettype wire
